// *** include/smstx_defines.vh ***
// Constants for the synchronous master serial transmitter/receiver.
// Assumes a 32-bit APB slave port with byte addresses in paddr[7:0].
`ifndef SMSTX_DEFINES_VH
`define SMSTX_DEFINES_VH

// Register byte offsets
`define SMSTX_OFS_IRQ_FLAGS    8'h00
`define SMSTX_OFS_IRQ_ENABLES  8'h04
`define SMSTX_OFS_IRQ_PRIORITY 8'h08
`define SMSTX_OFS_RX_STATUS    8'h0C
`define SMSTX_OFS_TX_BUFFER    8'h10
`define SMSTX_OFS_TX_STATUS    8'h14
`define SMSTX_OFS_BAUD_CTRL    8'h18
`define SMSTX_OFS_DIV_HIGH     8'h1C
`define SMSTX_OFS_DIV_LOW      8'h20
`define SMSTX_OFS_RX_BUFFER    8'h24

// Flag, enable and priority fields
`define SMSTX_BIT_RX_DONE      5
`define SMSTX_BIT_TX_EMPTY     4
`define SMSTX_IRQ_REG_MASK     8'h77

// Receive status and control fields
`define SMSTX_BIT_PORT_EN      7
`define SMSTX_BIT_RX_NINE      6
`define SMSTX_BIT_RX_SINGLE    5
`define SMSTX_BIT_RX_CONT      4
`define SMSTX_BIT_OVERRUN      1
`define SMSTX_BIT_RX_NINTH     0

// Transmit status and control fields
`define SMSTX_BIT_CLK_MASTER   7
`define SMSTX_BIT_TX_NINE      6
`define SMSTX_BIT_TX_EN        5
`define SMSTX_BIT_SYNC_MODE    4
`define SMSTX_BIT_HIGH_SPEED   2
`define SMSTX_BIT_SHIFT_EMPTY  1
`define SMSTX_BIT_TX_NINTH     0

// Baud control fields
`define SMSTX_BIT_CLK_POL      4
`define SMSTX_BIT_WIDE_DIV     3

// Reset values and counts
`define SMSTX_BYTE_ZERO        8'h00
`define SMSTX_DIV_ZERO         16'h0000
`define SMSTX_WORD_ZERO        9'h000
`define SMSTX_BITS_EIGHT_LAST  4'h7
`define SMSTX_BITS_NINE_LAST   4'h8
`define SMSTX_BIT_CNT_ZERO     4'h0
`define SMSTX_BIT_CNT_ONE      4'h1
`define SMSTX_HALF_CNT_ONE     16'h0001

`endif

// *** rtl/smstx_top.v ***
// Synchronous master serial port: APB registers, shift clock generator,
// half-duplex transmit and receive engine. Assumes one 20 MHz clock and a
// two-way data pin resolved outside from its output enable.
//
// Functional notes
// RQ1 - Shift register reloads from buffer only after last bit has left.
// RQ2 - Buffer to shift register move takes one cycle, then empty flag rises.
// RQ3 - Buffer empty flag ignores enable; only a buffer write clears it.
// RQ4 - Read-only shift-empty bit shows an empty shift register, no interrupt.
// RQ5 - Transmit shift register has no address; software cannot reach it.
// RQ6 - Software programs divisor bytes and wide select before sending.
// RQ7 - Port works only with sync mode, port enable and master bit set.
// RQ8 - Nine-bit transmit appends ninth bit from its control field.
// RQ9 - With transmit enabled, a buffer write starts a word.
// RQ10 - Reception starts from single or continuous receive enable.
// RQ11 - Received data sampled on falling edge of generated shift clock; code samples on the edge back to idle, rising when polarity bit is 1.
// RQ12 - Single receive takes exactly one word then stops.
// RQ13 - Continuous receive repeats words until its enable clears; code also stops receiving after an overrun until that enable clears.
// RQ14 - Both receive enables set behaves as continuous receive.
// RQ15 - Software keeps receive enables clear while setting up.
// RQ16 - Each received word sets done flag; interrupt if enabled.
// RQ17 - Nine-bit receive keeps the ninth bit in a readable field.
// RQ18 - Software reads status before reading the receive buffer.
// RQ19 - Clearing continuous receive clears receive errors.
// RQ20 - Half duplex: transmit and receive never overlap.
// RQ21 - Device drives shift clock; idle level follows polarity bit.
// RQ22 - Least significant bit first, one bit per shift clock period.
// RQ23 - Shift clock toggles only during a word, rests idle otherwise.
`timescale 1ns/10ps
`include "smstx_defines.vh"
`default_nettype none

module smstx_top (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Shift clock pin
  output reg         shift_clock_pin_out,
  output reg         shift_clock_pin_oe_n,
  // Serial data pin
  input  wire        serial_data_pin_in,
  output reg         serial_data_pin_out,
  output reg         serial_data_pin_oe_n,
  // Interrupt request
  output reg         irq_request
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_TX   = 2'b01;
  localparam [1:0] ST_RX   = 2'b10;

  // Software visible state
  reg  [7:0]  irq_enables_reg;
  reg  [7:0]  irq_priority_reg;
  reg         port_en_reg;
  reg         rx_nine_reg;
  reg         rx_single_reg;
  reg         rx_cont_reg;
  reg         overrun_reg;
  reg         rx_ninth_reg;
  reg         clk_master_reg;
  reg         tx_nine_reg;
  reg         tx_en_reg;
  reg         sync_mode_reg;
  reg         high_speed_reg;
  reg         tx_ninth_reg;
  reg         clk_pol_reg;
  reg         wide_div_reg;
  reg  [7:0]  div_high_reg;
  reg  [7:0]  div_low_reg;
  reg  [7:0]  tx_buffer_reg;
  reg         tx_full_reg;
  reg  [7:0]  rx_buffer_reg;
  reg         rx_done_flag_reg;

  // Engine state
  reg  [1:0]  state_reg;
  reg  [8:0]  shift_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [3:0]  last_bit_reg;
  reg  [15:0] half_cnt_reg;
  reg         phase_reg;
  reg         dt_meta_reg;
  reg         dt_sync_reg;

  // Decoded bus strobes, read mux and engine control nets
  wire        setup_phase;
  wire        access_done;
  wire        wr_en;
  wire        rd_rx_buffer;
  wire [15:0] divisor;
  wire        port_active;
  wire        half_tick;
  wire        last_bit;
  wire        tx_load;
  wire        rx_start;
  wire        rx_done;
  wire        rx_store;
  wire        shift_empty;
  reg  [7:0]  rd_data;
  reg         addr_ok;

  assign setup_phase  = psel & ~penable;
  assign access_done  = psel & penable & pready;
  assign wr_en        = access_done & pwrite;
  assign rd_rx_buffer = access_done & ~pwrite &
                        (paddr == `SMSTX_OFS_RX_BUFFER);

  // Divisor pair; narrow mode uses the low byte only
  assign divisor = wide_div_reg ? {div_high_reg, div_low_reg}
                                : {`SMSTX_BYTE_ZERO, div_low_reg};

  // Master mode needs all three configuration bits
  assign port_active = sync_mode_reg & port_en_reg & clk_master_reg; // RQ7

  assign half_tick = (half_cnt_reg == divisor);
  assign last_bit  = (bit_cnt_reg == last_bit_reg);

  // Reload only from idle, i.e. after the previous last bit left
  assign tx_load  = port_active & (state_reg == ST_IDLE) & tx_en_reg &
                    tx_full_reg; // RQ1 RQ9 RQ20
  // Receive waits for idle and yields to a pending transmit
  assign rx_start = port_active & (state_reg == ST_IDLE) & ~tx_load &
                    (rx_single_reg | rx_cont_reg) & ~overrun_reg; // RQ10 RQ20
  assign rx_done  = (state_reg == ST_RX) & half_tick & phase_reg &
                    last_bit;
  assign rx_store = rx_done & (~rx_done_flag_reg | rd_rx_buffer);

  assign shift_empty = (state_reg != ST_TX); // RQ4

  // Read multiplexer and address check; shift register has no address
  always @* begin
    rd_data = `SMSTX_BYTE_ZERO;
    addr_ok = 1'b1;
    if (paddr == `SMSTX_OFS_IRQ_FLAGS) begin
      rd_data[`SMSTX_BIT_RX_DONE]  = rx_done_flag_reg;
      rd_data[`SMSTX_BIT_TX_EMPTY] = ~tx_full_reg;
    end else if (paddr == `SMSTX_OFS_IRQ_ENABLES) begin
      rd_data = irq_enables_reg & `SMSTX_IRQ_REG_MASK;
    end else if (paddr == `SMSTX_OFS_IRQ_PRIORITY) begin
      rd_data = irq_priority_reg & `SMSTX_IRQ_REG_MASK;
    end else if (paddr == `SMSTX_OFS_RX_STATUS) begin
      rd_data[`SMSTX_BIT_PORT_EN]   = port_en_reg;
      rd_data[`SMSTX_BIT_RX_NINE]   = rx_nine_reg;
      rd_data[`SMSTX_BIT_RX_SINGLE] = rx_single_reg;
      rd_data[`SMSTX_BIT_RX_CONT]   = rx_cont_reg;
      rd_data[`SMSTX_BIT_OVERRUN]   = overrun_reg;
      rd_data[`SMSTX_BIT_RX_NINTH]  = rx_ninth_reg; // RQ17
    end else if (paddr == `SMSTX_OFS_TX_BUFFER) begin
      rd_data = tx_buffer_reg;
    end else if (paddr == `SMSTX_OFS_TX_STATUS) begin
      rd_data[`SMSTX_BIT_CLK_MASTER]  = clk_master_reg;
      rd_data[`SMSTX_BIT_TX_NINE]     = tx_nine_reg;
      rd_data[`SMSTX_BIT_TX_EN]       = tx_en_reg;
      rd_data[`SMSTX_BIT_SYNC_MODE]   = sync_mode_reg;
      rd_data[`SMSTX_BIT_HIGH_SPEED]  = high_speed_reg;
      rd_data[`SMSTX_BIT_SHIFT_EMPTY] = shift_empty; // RQ4
      rd_data[`SMSTX_BIT_TX_NINTH]    = tx_ninth_reg;
    end else if (paddr == `SMSTX_OFS_BAUD_CTRL) begin
      rd_data[`SMSTX_BIT_CLK_POL]  = clk_pol_reg;
      rd_data[`SMSTX_BIT_WIDE_DIV] = wide_div_reg;
    end else if (paddr == `SMSTX_OFS_DIV_HIGH) begin
      rd_data = div_high_reg;
    end else if (paddr == `SMSTX_OFS_DIV_LOW) begin
      rd_data = div_low_reg;
    end else if (paddr == `SMSTX_OFS_RX_BUFFER) begin
      rd_data = rx_buffer_reg;
    end else begin
      addr_ok = 1'b0; // RQ5
    end
  end

  // APB answer: ready in the cycle after setup, data captured at setup
  always @(posedge clock) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~addr_ok;
      if (setup_phase) begin
        prdata <= {24'h000000, rd_data};
      end
    end
  end

  // Control registers written by software
  always @(posedge clock) begin
    if (rst) begin
      irq_enables_reg  <= `SMSTX_BYTE_ZERO;
      irq_priority_reg <= `SMSTX_BYTE_ZERO;
      port_en_reg      <= 1'b0;
      rx_nine_reg      <= 1'b0;
      rx_cont_reg      <= 1'b0;
      clk_master_reg   <= 1'b0;
      tx_nine_reg      <= 1'b0;
      tx_en_reg        <= 1'b0;
      sync_mode_reg    <= 1'b0;
      high_speed_reg   <= 1'b0;
      tx_ninth_reg     <= 1'b0;
      clk_pol_reg      <= 1'b0;
      wide_div_reg     <= 1'b0;
      div_high_reg     <= `SMSTX_BYTE_ZERO;
      div_low_reg      <= `SMSTX_BYTE_ZERO;
    end else if (wr_en) begin
      if (paddr == `SMSTX_OFS_IRQ_ENABLES) begin
        irq_enables_reg <= pwdata[7:0] & `SMSTX_IRQ_REG_MASK;
      end else if (paddr == `SMSTX_OFS_IRQ_PRIORITY) begin
        irq_priority_reg <= pwdata[7:0] & `SMSTX_IRQ_REG_MASK;
      end else if (paddr == `SMSTX_OFS_RX_STATUS) begin
        port_en_reg <= pwdata[`SMSTX_BIT_PORT_EN];
        rx_nine_reg <= pwdata[`SMSTX_BIT_RX_NINE];
        rx_cont_reg <= pwdata[`SMSTX_BIT_RX_CONT];
      end else if (paddr == `SMSTX_OFS_TX_STATUS) begin
        clk_master_reg <= pwdata[`SMSTX_BIT_CLK_MASTER];
        tx_nine_reg    <= pwdata[`SMSTX_BIT_TX_NINE];
        tx_en_reg      <= pwdata[`SMSTX_BIT_TX_EN];
        sync_mode_reg  <= pwdata[`SMSTX_BIT_SYNC_MODE];
        high_speed_reg <= pwdata[`SMSTX_BIT_HIGH_SPEED];
        tx_ninth_reg   <= pwdata[`SMSTX_BIT_TX_NINTH];
      end else if (paddr == `SMSTX_OFS_BAUD_CTRL) begin
        clk_pol_reg  <= pwdata[`SMSTX_BIT_CLK_POL];
        wide_div_reg <= pwdata[`SMSTX_BIT_WIDE_DIV];
      end else if (paddr == `SMSTX_OFS_DIV_HIGH) begin
        div_high_reg <= pwdata[7:0];
      end else if (paddr == `SMSTX_OFS_DIV_LOW) begin
        div_low_reg <= pwdata[7:0];
      end
    end
  end

  // Single receive enable: software sets, hardware drops after one word unless continuous is set
  always @(posedge clock) begin
    if (rst) begin
      rx_single_reg <= 1'b0;
    end else if (wr_en && paddr == `SMSTX_OFS_RX_STATUS) begin
      rx_single_reg <= pwdata[`SMSTX_BIT_RX_SINGLE];
    end else if (rx_done && !rx_cont_reg) begin
      rx_single_reg <= 1'b0; // RQ12 RQ14
    end
  end

  // Transmit buffer and its full state; a write during a load refills it
  always @(posedge clock) begin
    if (rst) begin
      tx_buffer_reg <= `SMSTX_BYTE_ZERO;
      tx_full_reg   <= 1'b0;
    end else begin
      if (wr_en && paddr == `SMSTX_OFS_TX_BUFFER) begin
        tx_buffer_reg <= pwdata[7:0];
        tx_full_reg   <= 1'b1; // RQ3 RQ9
      end else if (tx_load) begin
        tx_full_reg <= 1'b0; // RQ2
      end
    end
  end

  // Receive buffer, done flag and overrun; a new word wins over a read
  always @(posedge clock) begin
    if (rst) begin
      rx_buffer_reg    <= `SMSTX_BYTE_ZERO;
      rx_ninth_reg     <= 1'b0;
      rx_done_flag_reg <= 1'b0;
      overrun_reg      <= 1'b0;
    end else begin
      if (rx_store) begin
        rx_buffer_reg    <= shift_reg[7:0];
        rx_ninth_reg     <= rx_nine_reg & shift_reg[8]; // RQ17
        rx_done_flag_reg <= 1'b1; // RQ16
      end else if (rd_rx_buffer) begin
        rx_done_flag_reg <= 1'b0;
      end
      if (rx_done && !rx_store) begin
        overrun_reg <= 1'b1;
      end else if (!rx_cont_reg) begin
        overrun_reg <= 1'b0; // RQ19
      end
    end
  end

  // Data pin synchroniser
  always @(posedge clock) begin
    if (rst) begin
      dt_meta_reg <= 1'b0;
      dt_sync_reg <= 1'b0;
    end else begin
      dt_meta_reg <= serial_data_pin_in;
      dt_sync_reg <= dt_meta_reg;
    end
  end

  // Shift engine: each bit is an active half then an idle half
  always @(posedge clock) begin
    if (rst) begin
      state_reg            <= ST_IDLE;
      shift_reg            <= `SMSTX_WORD_ZERO;
      bit_cnt_reg          <= `SMSTX_BIT_CNT_ZERO;
      last_bit_reg         <= `SMSTX_BITS_EIGHT_LAST;
      half_cnt_reg         <= `SMSTX_DIV_ZERO;
      phase_reg            <= 1'b0;
      shift_clock_pin_out  <= 1'b0;
      shift_clock_pin_oe_n <= 1'b1;
      serial_data_pin_out  <= 1'b0;
      serial_data_pin_oe_n <= 1'b1;
    end else begin
      shift_clock_pin_oe_n <= ~port_active; // RQ21
      if (!port_active) begin
        state_reg            <= ST_IDLE;
        half_cnt_reg         <= `SMSTX_DIV_ZERO;
        phase_reg            <= 1'b0;
        shift_clock_pin_out  <= clk_pol_reg;
        serial_data_pin_oe_n <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            half_cnt_reg        <= `SMSTX_DIV_ZERO;
            phase_reg           <= 1'b0;
            bit_cnt_reg         <= `SMSTX_BIT_CNT_ZERO;
            shift_clock_pin_out <= clk_pol_reg; // RQ21 RQ23
            if (tx_load) begin
              shift_reg <= {tx_nine_reg & tx_ninth_reg, tx_buffer_reg}; // RQ8
              last_bit_reg <= tx_nine_reg ? `SMSTX_BITS_NINE_LAST
                                          : `SMSTX_BITS_EIGHT_LAST;
              serial_data_pin_out  <= tx_buffer_reg[0]; // RQ22
              serial_data_pin_oe_n <= 1'b0;
              shift_clock_pin_out  <= ~clk_pol_reg;
              state_reg            <= ST_TX;
            end else if (rx_start) begin
              shift_reg    <= `SMSTX_WORD_ZERO;
              last_bit_reg <= rx_nine_reg ? `SMSTX_BITS_NINE_LAST
                                          : `SMSTX_BITS_EIGHT_LAST;
              serial_data_pin_oe_n <= 1'b1;
              shift_clock_pin_out  <= ~clk_pol_reg;
              state_reg            <= ST_RX;
            end else begin
              serial_data_pin_oe_n <= 1'b1;
            end
          end
          ST_TX, ST_RX: begin
            if (!half_tick) begin
              half_cnt_reg <= half_cnt_reg + `SMSTX_HALF_CNT_ONE;
            end else begin
              half_cnt_reg <= `SMSTX_DIV_ZERO;
              if (!phase_reg) begin
                // End of active half: clock back to idle, sample input
                phase_reg           <= 1'b1;
                shift_clock_pin_out <= clk_pol_reg;
                if (state_reg == ST_RX) begin
                  shift_reg[bit_cnt_reg] <= dt_sync_reg; // RQ11 RQ22
                end
              end else if (last_bit) begin
                // Word finished; clock rests at idle
                phase_reg            <= 1'b0;
                state_reg            <= ST_IDLE; // RQ1 RQ13 RQ23
                serial_data_pin_oe_n <= 1'b1;
              end else begin
                // Next bit: clock to active level, present next data bit
                phase_reg           <= 1'b0;
                bit_cnt_reg         <= bit_cnt_reg + `SMSTX_BIT_CNT_ONE;
                shift_clock_pin_out <= ~clk_pol_reg;
                if (state_reg == ST_TX) begin
                  serial_data_pin_out <=
                    shift_reg[bit_cnt_reg + `SMSTX_BIT_CNT_ONE]; // RQ22
                end
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Interrupt request from enabled flags
  always @(posedge clock) begin
    if (rst) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <=
        (rx_done_flag_reg & irq_enables_reg[`SMSTX_BIT_RX_DONE]) | // RQ16
        (~tx_full_reg & irq_enables_reg[`SMSTX_BIT_TX_EMPTY]);
    end
  end

endmodule // smstx_top

`default_nettype wire

// *** dv/smstx_monitor.sv ***
// Checker for the serial port's APB answers and transmit pin timing.
// Assumes the bench sets divisor 3, so each shift clock half is 4 cycles.
`timescale 1ns/10ps
`default_nettype none
module smstx_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        shift_clock_pin_out,
  input wire logic        shift_clock_pin_oe_n,
  input wire logic        serial_data_pin_out,
  input wire logic        serial_data_pin_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Address outside the register map
  wire unmapped = (paddr > 8'h24) || (paddr[1:0] != 2'h0);
  wire setup = psel && !penable;

  property p_ready_after_setup; setup |=> pready; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("pready missing after setup");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("pready longer than one cycle");
  property p_slverr; setup && unmapped |=> pslverr && prdata == 32'h0; endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped access not refused");
  property p_upper_zero; pready |-> prdata[31:8] == 24'h000000; endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits set");
  property p_oe_master;
    !serial_data_pin_oe_n |-> !shift_clock_pin_oe_n;
  endproperty
  a_oe_master: assert property (p_oe_master)
    else $error("data driven without master clock");
  property p_bit_clk;
    !serial_data_pin_oe_n && $changed(serial_data_pin_out)
      |-> $changed(shift_clock_pin_out);
  endproperty
  a_bit_clk: assert property (p_bit_clk)
    else $error("data changed away from clock edge");
  property p_half;
    !serial_data_pin_oe_n && $changed(shift_clock_pin_out)
      |=> $stable(shift_clock_pin_out) [*3];
  endproperty
  a_half: assert property (p_half)
    else $error("shift clock half period wrong");
  property p_word_start;
    $fell(serial_data_pin_oe_n) |-> $changed(shift_clock_pin_out);
  endproperty
  a_word_start: assert property (p_word_start)
    else $error("word started without clock edge");
  c_tx_word: cover property ($fell(serial_data_pin_oe_n));
  c_refused: cover property (pready && pslverr);
  c_rx_clock: cover property ($changed(shift_clock_pin_out)
    && serial_data_pin_oe_n);
endmodule // smstx_monitor

bind smstx_top smstx_monitor u_mon (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .shift_clock_pin_out(shift_clock_pin_out),
  .shift_clock_pin_oe_n(shift_clock_pin_oe_n),
  .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe_n(serial_data_pin_oe_n)
);
`default_nettype wire

// *** dv/smstx_slave_model.sv ***
// Behavioural serial slave clocked by the device's shift clock.
// Assumes the bench resolves the data line and gives the idle polarity.
`timescale 1ns/10ps
`default_nettype none
module smstx_slave_model (
  // Link pins
  input  wire logic       sck,
  input  wire logic       dat,
  // Set-up from the bench
  input  wire logic       pol,
  input  wire logic       nine,
  input  wire logic       drive_en,
  input  wire logic [8:0] tx_word,
  // Slave outputs
  output var  logic       drv,
  output var  logic [8:0] rx_word
);
  integer k;
  initial begin
    k = 0;
    drv = 1'b1;
    rx_word = 9'h000;
  end
  // Restart the bit index between frames
  always @(negedge drive_en) k = 0;
  // Active edge presents the next bit, idle edge captures the device bit
  always @(sck) begin
    if (sck !== pol) begin
      drv = tx_word[k];
      k = (k == (nine ? 8 : 7)) ? 0 : k + 1;
    end else begin
      rx_word = {dat, rx_word[8:1]};
    end
  end
endmodule // smstx_slave_model
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the synchronous master serial port.
// Assumes an APB master here and a pulled-up data line.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pol_s = 1'b0;
  logic        nine_s = 1'b0;
  logic        sen = 1'b0;
  logic [8:0]  sword = 9'h000;
  wire  [31:0] prdata;
  wire         pready, pslverr, sck, sck_oe_n, d_out, d_oe_n, irq, sdrv;
  wire  [8:0]  srx;
  wire         dline;
  integer      n_mismatch = 0;
  integer      num_checks = 0;
  integer      cycles = 0;

  always #25 clock = ~clock;
  // Data line: device, else slave, else pull-up
  assign dline = !d_oe_n ? d_out : (sen ? sdrv : 1'b1);

  smstx_top DUT (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shift_clock_pin_out(sck),
    .shift_clock_pin_oe_n(sck_oe_n), .serial_data_pin_in(dline),
    .serial_data_pin_out(d_out), .serial_data_pin_oe_n(d_oe_n),
    .irq_request(irq));
  smstx_slave_model u_slave (
    .sck(sck), .dat(dline), .pol(pol_s), .nine(nine_s), .drive_en(sen),
    .tx_word(sword), .drv(sdrv), .rx_word(srx));

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      complete_run;
    end
  end
  task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer, released after the edge that samples pready
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [7:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] q);
    logic e;
    apb(1'b0, a, 8'h00, q, e);
  endtask
  task wait_oe(input logic v);
    integer i;
    for (i = 0; i < 2000 && d_oe_n !== v; i++) @(negedge clock);
    chk("data enable", {8'h0, d_oe_n}, {8'h0, v});
  endtask
  task wait_bit(input logic [7:0] a, input integer b);
    logic [7:0] q;
    integer i;
    rd(a, q);
    for (i = 0; i < 300 && q[b] !== 1'b1; i++) rd(a, q);
    chk("status bit", {8'h0, q[b]}, 9'h001);
  endtask

  task t_reset;
    logic [7:0] q;
    logic e;
    rd(8'h00, q); chk("flags", {1'b0, q}, 9'h010);
    rd(8'h14, q); chk("tx status", {1'b0, q}, 9'h002);
    wr(8'h00, 8'hFF);
    rd(8'h00, q); chk("flags kept", {1'b0, q}, 9'h010);
    apb(1'b0, 8'h28, 8'h00, q, e); chk("slverr", {8'h0, e}, 9'h001);
    chk("clock oe idle", {8'h0, sck_oe_n}, 9'h001);
  endtask
  task t_setup;
    logic [7:0] q;
    wr(8'h20, 8'h03);
    wr(8'h1C, 8'h01);
    rd(8'h1C, q); chk("divisor high", {1'b0, q}, 9'h001);
    wr(8'h18, 8'h00);
    wr(8'h0C, 8'h80);
    wr(8'h14, 8'hB0);
    repeat (2) @(negedge clock);
    chk("clock oe", {8'h0, sck_oe_n}, 9'h000);
    chk("clock idle", {8'h0, sck}, 9'h000);
  endtask
  task t_tx;
    logic [7:0] q;
    wr(8'h10, 8'hA5);
    wait_oe(1'b0);
    wr(8'h10, 8'h3C);
    rd(8'h00, q); chk("buffer held", {8'h0, q[4]}, 9'h000);
    wait_oe(1'b1); chk("word one", {1'b0, srx[8:1]}, 9'h0A5);
    wait_oe(1'b0);
    rd(8'h14, q); chk("shifting", {1'b0, q}, 9'h0B0);
    rd(8'h00, q); chk("buffer empty", {8'h0, q[4]}, 9'h001);
    wr(8'h04, 8'h10);
    repeat (2) @(negedge clock);
    chk("tx irq", {8'h0, irq}, 9'h001);
    wr(8'h04, 8'h00);
    wait_oe(1'b1); chk("word two", {1'b0, srx[8:1]}, 9'h03C);
    rd(8'h14, q); chk("shift empty", {1'b0, q}, 9'h0B2);
  endtask
  task t_tx9_pol;
    pol_s <= 1'b1; nine_s <= 1'b1;
    wr(8'h1C, 8'h00);
    wr(8'h18, 8'h18);
    repeat (2) @(negedge clock);
    chk("clock idle high", {8'h0, sck}, 9'h001);
    wr(8'h14, 8'hF1);
    wr(8'h10, 8'h00);
    wait_oe(1'b0);
    wait_oe(1'b1); chk("ninth bit", srx, 9'h100);
    pol_s <= 1'b0; nine_s <= 1'b0;
    wr(8'h14, 8'h90);
    wr(8'h18, 8'h00);
  endtask
  task t_rx_single;
    logic [7:0] q;
    logic       last;
    integer     n;
    sword <= 9'h05A; sen <= 1'b1;
    wr(8'h04, 8'h20);
    wr(8'h0C, 8'hA0);
    wait_bit(8'h00, 5);
    chk("rx irq", {8'h0, irq}, 9'h001);
    rd(8'h0C, q); chk("single done", {1'b0, q}, 9'h080);
    rd(8'h24, q); chk("rx data", {1'b0, q}, 9'h05A);
    repeat (2) @(negedge clock);
    chk("irq cleared", {8'h0, irq}, 9'h000);
    n = 0;
    last = sck;
    repeat (100) begin
      @(negedge clock);
      if (sck !== last) n++;
      last = sck;
    end
    chk("clock quiet", n[8:0], 9'h000);
    wr(8'h04, 8'h00);
    sen <= 1'b0;
  endtask
  task t_rx_cont;
    logic [7:0] q;
    nine_s <= 1'b1; sword <= 9'h1C3; sen <= 1'b1;
    wr(8'h0C, 8'hC0);
    wr(8'h0C, 8'hF0);
    repeat (2) begin
      wait_bit(8'h00, 5);
      rd(8'h0C, q); chk("ninth rx", {8'h0, q[0]}, 9'h001);
      rd(8'h24, q); chk("cont data", {1'b0, q}, 9'h0C3);
    end
    wait_bit(8'h0C, 1);
    wr(8'h0C, 8'hC0);
    rd(8'h0C, q); chk("error cleared", {8'h0, q[1]}, 9'h000);
    sen <= 1'b0; nine_s <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_setup;
    t_tx;
    t_tx9_pol;
    t_rx_single;
    t_rx_cont;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
